// ---- common/csr_defines.svh ----
// Offsets, field masks, defaults and limits of the charge setpoint registers
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

`define CSR_CMD_CURRENT 8'h14
`define CSR_CMD_VOLTAGE 8'h15

`define CSR_ZERO16 16'h0000
`define CSR_CUR_RSVD_HI 16'he000
`define CSR_CUR_FIELD 16'h1fc0
`define CSR_VLT_RSVD_HI 16'h8000
`define CSR_VLT_FIELD 16'h7ff8

`define CSR_VLT_MIN_MV 16'h0400
`define CSR_VLT_MAX_MV 16'h4b00

`define CSR_DEF_1S_MV 16'h1068
`define CSR_DEF_2S_MV 16'h20d0
`define CSR_DEF_3S_MV 16'h3138
`define CSR_DEF_4S_MV 16'h41a0

`define CSR_PRECHG_MA 16'h0180
`define CSR_LOWV_MA 16'h07d0
`define CSR_1S_PRECHG_MV 16'h0bb8

`define CSR_CELLS_NONE 3'h0
`define CSR_CELLS_1 3'h1
`define CSR_CELLS_2 3'h2
`define CSR_CELLS_3 3'h3
`define CSR_CELLS_4 3'h4

`define CSR_STRAP_WAIT 2'h3
`define CSR_STRAP_STEP 2'h1

`endif

// ---- common/csr_pkg.sv ----
// Types shared by the charge setpoint register block
package csr_pkg;

  typedef enum logic [1:0] {
    CSR_CLAMP_NONE = 2'b00,
    CSR_CLAMP_PRECHG = 2'b01,
    CSR_CLAMP_LOWV = 2'b10
  } csr_clamp_t;

  typedef enum logic [1:0] {
    CSR_ST_STRAP = 2'b00,
    CSR_ST_IDLE = 2'b01,
    CSR_ST_CHARGE = 2'b10
  } csr_state_t;

endpackage

// ---- src/csr_sync2.sv ----
// Two-flop synchroniser for pin levels and reset release
`timescale 1ns/100ps
module csr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- src/csr_setpoint_regs.sv ----
// Charge current and voltage setpoint registers with current clamps
`timescale 1ns/100ps
`include "csr_defines.svh"

// What this block does
// RULE_01: Current bit 7 adds 128 mA when set, nothing when clear.
// RULE_02: Current bit 6 is the lowest current bit, adding 64 mA.
// RULE_03: Current bits 5 to 0 are unused and never affect current.
// RULE_04: Linear pre-charge, 2-4 cells: rail held at minimum, 384 mA cap.
// RULE_05: One cell below 3 V is pre-charge, current capped at 384 mA.
// RULE_06: One cell: switch stays linear until battery passes minimum rail.
// RULE_07: One cell between 3 V and minimum rail: current capped at 2 A.
// RULE_08: Voltage spans 1.024 V to 19.2 V in 8 mV steps, one write.
// RULE_09: Voltage writes outside that span are dropped, old value kept.
// RULE_10: At power-on the voltage default follows cell count pin.
// RULE_11: With power good, a current write starts charging; voltage default.
// RULE_12: Host writes voltage before current for non-4.2 V cells.
// RULE_13: Zero voltage write keeps voltage and clears current to zero.
// RULE_14: Voltage field is bits 14 to 3, 16384 mV down to 8 mV.
// RULE_15: Current field is bits 12 to 6, 4096 mA down to 64 mA.
// RULE_16: Current clears on battery or source loss, reset, zero, watchdog.
// RULE_17: A one in the unused upper bits makes the write invalid.
// RULE_18: Invalid writes are refused whole; reads give last accepted value.
// RULE_19: Applied current is the register clamped by the active limit.
module csr_setpoint_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  input wire logic register_reset_cmd,
  input wire logic watchdog_expired,
  input wire logic linear_precharge_enable,
  input wire logic [15:0] battery_sense_negative_mv,
  input wire logic [15:0] min_sys_voltage_mv,
  input wire logic input_power_good,
  input wire logic input_source_present,
  input wire logic [2:0] cell_count_battery_present,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_wr_ack,
  output logic reg_wr_invalid,
  output logic regs_ready,
  output logic [15:0] charge_current_setpoint,
  output logic [15:0] charge_voltage_setpoint,
  output logic [15:0] applied_current_ma,
  output csr_pkg::csr_clamp_t clamp_mode,
  output logic charge_enable,
  output logic battery_switch_fet_linear,
  output logic sys_rail_at_min
);
  import csr_pkg::*;

  logic rst_n;
  logic [4:0] pins_sync;
  logic power_good_s;
  logic source_present_s;
  logic [2:0] cells_s;
  logic battery_present_s;

  csr_sync2 #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk(sys_clk),
    .rst_n(resetn),
    .d(1'b1),
    .q(rst_n)
  );

  csr_sync2 #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({input_power_good, input_source_present,
        cell_count_battery_present}),
    .q(pins_sync)
  );

  assign power_good_s = pins_sync[4];
  assign source_present_s = pins_sync[3];
  assign cells_s = pins_sync[2:0];
  assign battery_present_s = (cells_s != `CSR_CELLS_NONE);

  // Voltage default picked from the cell count; codes above four act as four
  function automatic logic [15:0] default_mv(input logic [2:0] cells);
    logic [15:0] mv;
    mv = `CSR_DEF_4S_MV;
    unique case (cells)
      `CSR_CELLS_NONE: mv = `CSR_DEF_1S_MV;
      `CSR_CELLS_1: mv = `CSR_DEF_1S_MV;
      `CSR_CELLS_2: mv = `CSR_DEF_2S_MV;
      `CSR_CELLS_3: mv = `CSR_DEF_3S_MV;
      default: mv = `CSR_DEF_4S_MV;
    endcase
    return mv;
  endfunction

  // Register group
  csr_state_t state_reg, state_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [2:0] cell_cnt_reg, cell_cnt_next;
  logic [15:0] cur_reg, cur_next;
  logic [15:0] vlt_reg, vlt_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rd_valid_reg, rd_valid_next;
  logic wr_ack_reg, wr_ack_next;
  logic wr_inv_reg, wr_inv_next;
  logic chg_en_reg, chg_en_next;
  logic ready_reg, ready_next;

  always_comb begin
    logic [15:0] cur_field;
    logic [15:0] vlt_field;
    logic zero_vlt_write;
    logic clear_current;
    cur_field = reg_wdata & `CSR_CUR_FIELD; // RULE_01 RULE_02 RULE_03 RULE_15
    vlt_field = reg_wdata & `CSR_VLT_FIELD; // RULE_14
    zero_vlt_write = 1'b0;
    clear_current = 1'b0;
    state_next = state_reg;
    strap_cnt_next = strap_cnt_reg;
    cell_cnt_next = cell_cnt_reg;
    cur_next = cur_reg;
    vlt_next = vlt_reg;
    rdata_next = rdata_reg;
    rd_valid_next = 1'b0;
    wr_ack_next = 1'b0;
    wr_inv_next = 1'b0;
    ready_next = ready_reg;
    unique case (state_reg)
      CSR_ST_STRAP: begin
        // Wait for the pin synchroniser to fill before taking the strap
        if (strap_cnt_reg == `CSR_STRAP_WAIT) begin
          cell_cnt_next = cells_s;
          vlt_next = default_mv(cells_s); // RULE_10
          ready_next = 1'b1;
          state_next = CSR_ST_IDLE;
        end else begin
          strap_cnt_next = strap_cnt_reg + `CSR_STRAP_STEP;
        end
      end
      default: begin
        if (reg_wr_en && reg_cmd == `CSR_CMD_CURRENT) begin
          if ((reg_wdata & `CSR_CUR_RSVD_HI) != `CSR_ZERO16) begin
            wr_inv_next = 1'b1; // RULE_17 RULE_18
          end else begin
            // Low bits stored as zero, so they read back and act as zero
            cur_next = cur_field; // RULE_03
            wr_ack_next = 1'b1;
            if (power_good_s && cur_field != `CSR_ZERO16) begin
              state_next = CSR_ST_CHARGE; // RULE_11
            end else if (cur_field == `CSR_ZERO16) begin
              state_next = CSR_ST_IDLE;
            end
          end
        end else if (reg_wr_en && reg_cmd == `CSR_CMD_VOLTAGE) begin
          if ((reg_wdata & `CSR_VLT_RSVD_HI) != `CSR_ZERO16) begin
            wr_inv_next = 1'b1; // RULE_17 RULE_18
          end else if (vlt_field == `CSR_ZERO16) begin
            zero_vlt_write = 1'b1; // RULE_13
            wr_ack_next = 1'b1;
          end else if (vlt_field < `CSR_VLT_MIN_MV ||
                       vlt_field > `CSR_VLT_MAX_MV) begin
            wr_inv_next = 1'b1; // RULE_09
          end else begin
            vlt_next = vlt_field; // RULE_08
            wr_ack_next = 1'b1;
          end
        end else if (reg_wr_en) begin
          wr_inv_next = 1'b1;
        end
        if (reg_rd_en) begin
          rd_valid_next = 1'b1;
          if (reg_cmd == `CSR_CMD_CURRENT) begin
            rdata_next = cur_reg; // RULE_18
          end else if (reg_cmd == `CSR_CMD_VOLTAGE) begin
            rdata_next = vlt_reg; // RULE_18
          end else begin
            rdata_next = `CSR_ZERO16;
          end
        end
        // Hardware clears beat a host write in the same cycle
        clear_current = zero_vlt_write || !battery_present_s ||
                        !source_present_s || register_reset_cmd ||
                        watchdog_expired; // RULE_16
        if (clear_current) begin
          cur_next = `CSR_ZERO16; // RULE_13 RULE_16
          state_next = CSR_ST_IDLE;
        end
        if (register_reset_cmd) begin
          vlt_next = default_mv(cell_cnt_reg); // RULE_10
        end
        // Losing power good pauses charge; setpoint is kept for return
        if (state_next == CSR_ST_CHARGE && !power_good_s) begin
          state_next = CSR_ST_CHARGE;
        end
      end
    endcase
    chg_en_next = (state_next == CSR_ST_CHARGE) && power_good_s; // RULE_11
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CSR_ST_STRAP;
      strap_cnt_reg <= 2'h0;
      cell_cnt_reg <= `CSR_CELLS_NONE;
      cur_reg <= `CSR_ZERO16;
      vlt_reg <= `CSR_ZERO16;
      rdata_reg <= `CSR_ZERO16;
      rd_valid_reg <= 1'b0;
      wr_ack_reg <= 1'b0;
      wr_inv_reg <= 1'b0;
      chg_en_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strap_cnt_reg <= strap_cnt_next;
      cell_cnt_reg <= cell_cnt_next;
      cur_reg <= cur_next;
      vlt_reg <= vlt_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
      wr_ack_reg <= wr_ack_next;
      wr_inv_reg <= wr_inv_next;
      chg_en_reg <= chg_en_next;
      ready_reg <= ready_next;
    end
  end

  // Clamp group
  csr_clamp_t clamp_reg, clamp_next;
  logic [15:0] applied_reg, applied_next;
  logic linear_reg, linear_next;
  logic rail_min_reg, rail_min_next;

  always_comb begin
    logic single_cell;
    logic below_min;
    single_cell = (cell_cnt_reg == `CSR_CELLS_1) ||
                  (cell_cnt_reg == `CSR_CELLS_NONE);
    below_min = battery_sense_negative_mv <= min_sys_voltage_mv;
    clamp_next = CSR_CLAMP_NONE;
    linear_next = 1'b0;
    rail_min_next = 1'b0;
    if (linear_precharge_enable && chg_en_reg) begin
      if (!single_cell && below_min) begin
        clamp_next = CSR_CLAMP_PRECHG; // RULE_04
        linear_next = 1'b1;
        rail_min_next = 1'b1; // RULE_04
      end else if (single_cell &&
                   battery_sense_negative_mv < `CSR_1S_PRECHG_MV) begin
        clamp_next = CSR_CLAMP_PRECHG; // RULE_05
        linear_next = 1'b1; // RULE_06
      end else if (single_cell && below_min) begin
        clamp_next = CSR_CLAMP_LOWV; // RULE_07
        linear_next = 1'b1; // RULE_06
      end
    end
    // Register value in mA equals the masked field, bit 6 weighing 64 mA
    applied_next = `CSR_ZERO16;
    if (chg_en_reg) begin
      unique case (clamp_next)
        CSR_CLAMP_PRECHG: begin
          applied_next = (cur_reg > `CSR_PRECHG_MA) ?
                         `CSR_PRECHG_MA : cur_reg; // RULE_19
        end
        CSR_CLAMP_LOWV: begin
          applied_next = (cur_reg > `CSR_LOWV_MA) ?
                         `CSR_LOWV_MA : cur_reg; // RULE_07 RULE_19
        end
        default: begin
          applied_next = cur_reg; // RULE_19
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_reg <= CSR_CLAMP_NONE;
      applied_reg <= `CSR_ZERO16;
      linear_reg <= 1'b0;
      rail_min_reg <= 1'b0;
    end else begin
      clamp_reg <= clamp_next;
      applied_reg <= applied_next;
      linear_reg <= linear_next;
      rail_min_reg <= rail_min_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign reg_wr_ack = wr_ack_reg;
  assign reg_wr_invalid = wr_inv_reg;
  assign regs_ready = ready_reg;
  assign charge_current_setpoint = cur_reg;
  assign charge_voltage_setpoint = vlt_reg;
  assign applied_current_ma = applied_reg;
  assign clamp_mode = clamp_reg;
  assign charge_enable = chg_en_reg;
  assign battery_switch_fet_linear = linear_reg;
  assign sys_rail_at_min = rail_min_reg;

endmodule

// ---- tb/csr_setpoint_regs_asserts.sv ----
// Port-level assertions for the charge setpoint register block
`timescale 1ns/100ps
module csr_setpoint_regs_asserts
  import csr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  input wire logic register_reset_cmd,
  input wire logic watchdog_expired,
  input wire logic regs_ready,
  input wire logic reg_wr_ack,
  input wire logic reg_wr_invalid,
  input wire logic charge_enable,
  input wire logic [15:0] charge_current_setpoint,
  input wire logic [15:0] charge_voltage_setpoint,
  input wire logic [15:0] applied_current_ma,
  input wire csr_clamp_t clamp_mode
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic [15:0] vf;
  logic wr_ok;
  assign vf = reg_wdata & 16'h7ff8;
  // Reset command reloads both registers, so it is kept out of write checks
  assign wr_ok = reg_wr_en && regs_ready && !register_reset_cmd;
  property p_answer;
    wr_ok |=> reg_wr_ack != reg_wr_invalid;
  endproperty
  a_answer: assert property (p_answer) else $error("one answer");
  property p_cur_rsvd;
    wr_ok && reg_cmd == 8'h14 && reg_wdata[15:13] != 3'h0 |=> reg_wr_invalid;
  endproperty
  a_cur_rsvd: assert property (p_cur_rsvd) else $error("rsvd");
  property p_v_bad;
    wr_ok && reg_cmd == 8'h15 && (reg_wdata[15] || vf != 16'h0000 &&
      (vf < 16'h0400 || vf > 16'h4b00)) |=> reg_wr_invalid &&
      $stable(charge_voltage_setpoint);
  endproperty
  a_v_bad: assert property (p_v_bad) else $error("v range");
  property p_v_zero;
    wr_ok && reg_cmd == 8'h15 && reg_wdata[15:3] == 13'h0000 |=> reg_wr_ack
      && charge_current_setpoint == 16'h0000 && !charge_enable &&
      $stable(charge_voltage_setpoint);
  endproperty
  a_v_zero: assert property (p_v_zero) else $error("v zero");
  property p_cur_take;
    wr_ok && reg_cmd == 8'h14 && reg_wdata[15:13] == 3'h0 |=> reg_wr_ack &&
      (charge_current_setpoint == ($past(reg_wdata) & 16'h1fc0) ||
      charge_current_setpoint == 16'h0000);
  endproperty
  a_cur_take: assert property (p_cur_take) else $error("cur");
  property p_pre;
    clamp_mode == CSR_CLAMP_PRECHG |-> applied_current_ma <= 16'h0180;
  endproperty
  a_pre: assert property (p_pre) else $error("pre cap");
  property p_lowv;
    clamp_mode == CSR_CLAMP_LOWV |-> applied_current_ma <= 16'h07d0;
  endproperty
  a_lowv: assert property (p_lowv) else $error("lowv cap");
  property p_wd;
    watchdog_expired && regs_ready |=> charge_current_setpoint == 16'h0000
      && !charge_enable;
  endproperty
  a_wd: assert property (p_wd) else $error("wd clear");
  c_zero: cover property (wr_ok && reg_cmd == 8'h15 && vf == 16'h0000);
  c_pre: cover property (clamp_mode == CSR_CLAMP_PRECHG);
  c_lowv: cover property (clamp_mode == CSR_CLAMP_LOWV);
endmodule

bind csr_setpoint_regs csr_setpoint_regs_asserts u_chk (.*);

// ---- tb/csr_host.sv ----
// Host model issuing single register requests to the setpoint block
`timescale 1ns/100ps
module csr_host (
  input wire logic sys_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_cmd,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  task automatic acc(input logic w, input logic r, input logic [7:0] c,
    input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_cmd = c;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // Idle lines show inverted leftovers so stale data never looks valid
    reg_cmd = ~c;
    reg_wdata = ~d;
  endtask
endmodule

// ---- tb/csr_setpoint_regs_tb.sv ----
// Self-checking bench for the charge setpoint register block
`timescale 1ns/100ps
`define CK(n, e, s) n_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end
module csr_setpoint_regs_tb;
  import csr_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, register_reset_cmd = 1'b0;
  logic watchdog_expired = 1'b0, linear_precharge_enable = 1'b1;
  logic input_power_good = 1'b1, input_source_present = 1'b1;
  logic [15:0] battery_sense_negative_mv = 16'h0fa0;
  logic [15:0] min_sys_voltage_mv = 16'h0e10;
  logic [2:0] cell_count_battery_present = 3'h1;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_wr_ack, reg_wr_invalid;
  logic regs_ready, charge_enable, battery_switch_fet_linear, sys_rail_at_min;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata, charge_current_setpoint;
  logic [15:0] charge_voltage_setpoint, applied_current_ma;
  csr_clamp_t clamp_mode;
  int fail_count = 0, n_checks = 0, cur, vlt, run;
  logic [31:0] rs = 32'h6;
  logic [23:0] tv[] = '{24'h14003f, 24'h142000, 24'h140040, 24'h140080,
    24'h150400, 24'h1503f8, 24'h154b00, 24'h154b08, 24'h158400, 24'h150007,
    24'h160100};
  int vb[] = '{2500, 3300, 3600, 4000};
  csr_host h (.*);
  csr_setpoint_regs dut (.*);
  always #20 sys_clk = ~sys_clk;
  function automatic logic [15:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  function automatic int amp_exp();
    int lim;
    lim = cur;
    if (run == 0 || !input_power_good) return 0;
    if (linear_precharge_enable &&
      battery_sense_negative_mv <= min_sys_voltage_mv)
      lim = (cell_count_battery_present > 3'h1 ||
        battery_sense_negative_mv < 16'h0bb8) ? 384 : 2000;
    return cur < lim ? cur : lim;
  endfunction
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    int f;
    logic bad;
    f = d & (c == 8'h14 ? 16'h1fc0 : 16'h7ff8);
    bad = c == 8'h14 ? d[15:13] != 3'h0 : c != 8'h15 || d[15] ||
      (f != 0 && (f < 1024 || f > 19200));
    h.acc(1'b1, 1'b0, c, d);
    if (!bad && c == 8'h14) begin
      cur = f;
      run = f != 0 && input_power_good;
    end else if (!bad && f == 0) begin
      cur = 0;
      run = 0;
    end else if (!bad) vlt = f;
    `CK("invalid", bad, reg_wr_invalid)
    `CK("ack", !bad, reg_wr_ack)
    `CK("current", cur[15:0], charge_current_setpoint)
    `CK("voltage", vlt[15:0], charge_voltage_setpoint)
    `CK("charging", run != 0, charge_enable)
  endtask
  task automatic rd(input logic [7:0] c);
    logic [15:0] e;
    e = c == 8'h14 ? cur[15:0] : c == 8'h15 ? vlt[15:0] : 16'h0000;
    h.acc(1'b0, 1'b1, c, 16'h0000);
    `CK("rd_valid", 1'b1, reg_rd_valid)
    `CK("rdata", e, reg_rdata)
  endtask
  task automatic rst(input logic [2:0] n);
    resetn = 1'b0;
    cell_count_battery_present = n;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    for (int i = 0; i < 20 && regs_ready !== 1'b1; i++) @(negedge sys_clk);
    cur = 0;
    run = 0;
    vlt = n == 3'h0 ? 4200 : 4200 * n;
    `CK("ready", 1'b1, regs_ready)
    `CK("default", vlt[15:0], charge_voltage_setpoint)
  endtask
  task automatic clr(input int k);
    wr(8'h15, 16'h1f40);
    wr(8'h14, 16'h0800);
    case (k)
      0: watchdog_expired = 1'b1;
      1: register_reset_cmd = 1'b1;
      2: input_source_present = 1'b0;
      default: cell_count_battery_present = 3'h0;
    endcase
    @(negedge sys_clk);
    watchdog_expired = 1'b0;
    register_reset_cmd = 1'b0;
    // Pins pass two sync flops before the clear lands
    repeat (4) @(negedge sys_clk);
    cur = 0;
    run = 0;
    if (k == 1) vlt = 12600;
    `CK("cleared", 16'h0000, charge_current_setpoint)
    `CK("stopped", 1'b0, charge_enable)
    `CK("v_reload", vlt[15:0], charge_voltage_setpoint)
    input_source_present = 1'b1;
    cell_count_battery_present = 3'h3;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [15:0] r;
    for (int n = 0; n < 5; n++) rst(n[2:0]);
    $display("test strap defaults done");
    foreach (tv[i]) begin
      wr(tv[i][23:16], tv[i][15:0]);
      rd(tv[i][23:16]);
    end
    repeat (40) begin
      r = rnd();
      wr(r[2:0] == 3'h0 ? 8'h16 : {7'h0a, r[3]}, rnd() >> r[7:4]);
      rd({7'h0a, r[3]});
    end
    $display("test field writes done");
    rst(3'h1);
    wr(8'h15, 16'h0e10);
    wr(8'h14, 16'h0fc0);
    foreach (vb[i]) begin
      battery_sense_negative_mv = vb[i][15:0];
      repeat (3) @(negedge sys_clk);
      `CK("amp_1s", amp_exp(), applied_current_ma)
      `CK("linear", vb[i] <= 3600, battery_switch_fet_linear)
      `CK("clamp_1s", vb[i] < 3000 ? 2'h1 : vb[i] <= 3600 ? 2'h2 : 2'h0,
        clamp_mode)
    end
    $display("test single cell clamps done");
    battery_sense_negative_mv = 16'h1388;
    min_sys_voltage_mv = 16'h1b58;
    rst(3'h3);
    wr(8'h14, 16'h0fc0);
    for (int l = 1; l >= 0; l--) begin
      linear_precharge_enable = l[0];
      repeat (3) @(negedge sys_clk);
      `CK("amp_3s", amp_exp(), applied_current_ma)
      `CK("rail_min", l[0], sys_rail_at_min)
      `CK("clamp_3s", {1'b0, l[0]}, clamp_mode)
    end
    $display("test multi cell clamp done");
    for (int k = 0; k < 4; k++) clr(k);
    $display("test clears done");
    // Power good loss pauses charging but keeps the setpoint for its return
    wr(8'h14, 16'h0400);
    input_power_good = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CK("pg_low", 1'b0, charge_enable)
    `CK("pg_keep", 16'h0400, charge_current_setpoint)
    `CK("pg_amp", amp_exp(), applied_current_ma)
    input_power_good = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CK("pg_back", 1'b1, charge_enable)
    `CK("pg_amp_back", amp_exp(), applied_current_ma)
    $display("test power good done");
    wrap_up();
  end
endmodule
